// File: rst_wdt_pkg.sv
package rst_wdt_pkg;

  localparam int CLK_PERIOD_NS = 4;
  // supply settle before the core clock is released
  localparam int SETTLE_TIME_NS = 1000000;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int WD_BASE_LOG2 = 12;
  localparam int WD_STEP_LOG2 = 3;
  localparam int WD_CNT_W = 24;
  localparam int WD_PRE_RESET_CYC = 512;
  localparam int PRE_W = 10;
  localparam int HOLD_CYC = 4;
  localparam int HOLD_W = 3;

  localparam logic [15:0] BOOT_ADDR = 16'h8000;
  localparam logic [7:0] HOST_RESET_CMD = 8'hBB;

  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_WDOG_CTRL = 12'h000;
  localparam logic [11:0] OFS_RSTCN = 12'h004;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h80;
  localparam logic [7:0] RSTCN_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_BROWNOUT = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CPU = 2'b10,
    ST_SYSRST = 2'b11
  } seq_state_t;

  // watchdog_control_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic por_flag;
    logic rsvd;
    logic [1:0] timeout_select;
    logic wd_enable;
    logic watchdog_reset_flag;
    logic wd_int_flag;
    logic restart;
  } wdog_ctrl_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic host_flag;
    logic pin_flag;
    logic programming_done_bit;
  } rstcn_t;

endpackage

// File: reset_and_watchdog_control.sv
// Functional notes
// - core clock stays gated until supply has been above threshold 1 ms.
// - startup reset forces every register to its reset value.
// - startup reset sets the startup cause flag, control bit 7.
// - on reset release, fetch starts at boot address 8000h.
// - brownout asserts reset at once and holds it while present.
// - after brownout, wait settle time; brownout meanwhile returns there.
// - brownout detection stays active in CPU state.
// - after power-up the sequencer always starts in brownout state.
// - brownout reset acts exactly like startup reset.
// - two-bit field at bits 5:4 picks one of four timeouts.
// - watchdog interrupt at timeout, reset 512 clocks later.
// - a watchdog reset lasts four clock cycles.
// - watchdog reset sets a readable watchdog cause flag.
// - software restarts the watchdog; reaching max count resets.
// - low reset pin holds reset; boot restart once released.
// - host command BBh gives an internal reset like the pin.
// - setting the programming done bit causes a system reset.
module reset_and_watchdog_control #(
  parameter int settle_cycles = rst_wdt_pkg::SETTLE_CYC,
  parameter int wd_base_log2 = rst_wdt_pkg::WD_BASE_LOG2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic brownout,
  input wire logic rst_pin_n,
  input wire logic host_cmd_valid,
  input wire logic [7:0] host_cmd_data,
  input wire logic awvalid,
  output logic awready,
  input wire logic [rst_wdt_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [rst_wdt_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic core_clk_en,
  output logic por_reset,
  output logic sys_reset,
  output logic fetch_start,
  output logic [15:0] boot_addr,
  output logic wdt_irq
);

  localparam int SW = $clog2(settle_cycles + 1);

  rst_wdt_pkg::seq_state_t state_q, state_d;
  rst_wdt_pkg::wdog_ctrl_t watchdog_control_register_q;
  rst_wdt_pkg::rstcn_t reset_control_register_q;
  logic bo_m_q, bo_s_q, pin_m_q, pin_s_q;
  logic [SW-1:0] settle_cnt_q;
  logic [rst_wdt_pkg::HOLD_W-1:0] hold_cnt_q;
  logic [rst_wdt_pkg::WD_CNT_W-1:0] wd_cnt_q;
  logic [rst_wdt_pkg::PRE_W-1:0] pre_cnt_q;
  logic pend_q;
  logic core_clk_en_q, por_reset_q, sys_reset_q, fetch_start_q;
  logic [15:0] boot_addr_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic have_aw_q, have_w_q;
  logic [rst_wdt_pkg::ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  function automatic logic is_reg(input logic [rst_wdt_pkg::ADDR_W-1:0] a);
    return (a == rst_wdt_pkg::OFS_WDOG_CTRL) || (a == rst_wdt_pkg::OFS_RSTCN);
  endfunction

  function automatic logic [rst_wdt_pkg::WD_CNT_W-1:0] timeout_last(
    input logic [1:0] sel);
    int sh;
    sh = wd_base_log2 + rst_wdt_pkg::WD_STEP_LOG2 * int'(sel);
    return (rst_wdt_pkg::WD_CNT_W'(1) << sh) - rst_wdt_pkg::WD_CNT_W'(1);
  endfunction

  // two-stage synchronisers for the supply monitor and the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_m_q <= 1'b1;
      bo_s_q <= 1'b1;
      pin_m_q <= 1'b1;
      pin_s_q <= 1'b1;
    end else begin
      bo_m_q <= brownout;
      bo_s_q <= bo_m_q;
      pin_m_q <= rst_pin_n;
      pin_s_q <= pin_m_q;
    end
  end

  // bus handshakes and decoded write
  logic aw_ok, w_ok, ar_ok, got_aw, got_w, do_write;
  logic [rst_wdt_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_wdog, wr_rstcn;
  assign aw_ok = awvalid & awready_q;
  assign w_ok = wvalid & wready_q;
  assign ar_ok = arvalid & arready_q;
  assign got_aw = have_aw_q | aw_ok;
  assign got_w = have_w_q | w_ok;
  assign do_write = got_aw & got_w & ~bvalid_q;
  assign wr_addr = aw_ok ? awaddr : waddr_q;
  assign wr_data = w_ok ? wdata : wdata_q;
  assign wr_strb = w_ok ? wstrb : wstrb_q;
  assign wr_wdog = do_write & wr_strb[0]
                   & (wr_addr == rst_wdt_pkg::OFS_WDOG_CTRL);
  assign wr_rstcn = do_write & wr_strb[0]
                    & (wr_addr == rst_wdt_pkg::OFS_RSTCN);

  // reset sources seen while running
  logic in_cpu, wd_restart, wd_int_set, wd_trip, host_hit, sys_trig;
  assign in_cpu = state_q == rst_wdt_pkg::ST_CPU;
  assign wd_restart = wr_wdog & wr_data[0];
  assign wd_int_set = in_cpu & watchdog_control_register_q.wd_enable
    & ~pend_q & ~wd_restart
    & (wd_cnt_q == timeout_last(watchdog_control_register_q.timeout_select));
  assign wd_trip = in_cpu & pend_q & ~wd_restart
    & (pre_cnt_q == rst_wdt_pkg::PRE_W'(rst_wdt_pkg::WD_PRE_RESET_CYC - 1));
  assign host_hit = in_cpu & host_cmd_valid
                    & (host_cmd_data == rst_wdt_pkg::HOST_RESET_CMD);
  assign sys_trig = wd_trip | ~pin_s_q | host_hit
                    | reset_control_register_q.programming_done_bit;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rst_wdt_pkg::ST_BROWNOUT: begin
        if (!bo_s_q) state_d = rst_wdt_pkg::ST_SETTLE;
      end
      rst_wdt_pkg::ST_SETTLE: begin
        if (bo_s_q) state_d = rst_wdt_pkg::ST_BROWNOUT;
        else if (settle_cnt_q == SW'(settle_cycles - 1))
          state_d = rst_wdt_pkg::ST_CPU;
      end
      rst_wdt_pkg::ST_CPU: begin
        if (bo_s_q) state_d = rst_wdt_pkg::ST_BROWNOUT;
        else if (sys_trig) state_d = rst_wdt_pkg::ST_SYSRST;
      end
      rst_wdt_pkg::ST_SYSRST: begin
        if (bo_s_q) state_d = rst_wdt_pkg::ST_BROWNOUT;
        else if (pin_s_q && hold_cnt_q ==
                 rst_wdt_pkg::HOLD_W'(rst_wdt_pkg::HOLD_CYC - 1))
          state_d = rst_wdt_pkg::ST_CPU;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state_q <= rst_wdt_pkg::ST_BROWNOUT;
    else state_q <= state_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != rst_wdt_pkg::ST_SETTLE) settle_cnt_q <= '0;
    else settle_cnt_q <= settle_cnt_q + SW'(1);
  end

  // reset width counter, saturates while the pin stays low
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != rst_wdt_pkg::ST_SYSRST) hold_cnt_q <= '0;
    else if (hold_cnt_q != rst_wdt_pkg::HOLD_W'(rst_wdt_pkg::HOLD_CYC - 1))
      hold_cnt_q <= hold_cnt_q + rst_wdt_pkg::HOLD_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_en_q <= 1'b0;
      por_reset_q <= 1'b1;
      sys_reset_q <= 1'b1;
      fetch_start_q <= 1'b0;
      boot_addr_q <= rst_wdt_pkg::BOOT_ADDR;
    end else begin
      core_clk_en_q <= state_d inside {rst_wdt_pkg::ST_CPU,
                                       rst_wdt_pkg::ST_SYSRST};
      por_reset_q <= state_d inside {rst_wdt_pkg::ST_BROWNOUT,
                                     rst_wdt_pkg::ST_SETTLE};
      sys_reset_q <= state_d != rst_wdt_pkg::ST_CPU;
      fetch_start_q <= (state_d == rst_wdt_pkg::ST_CPU) && !in_cpu;
      boot_addr_q <= rst_wdt_pkg::BOOT_ADDR;
    end
  end

  // watchdog count, then the pre-reset interval
  always_ff @(posedge aclk) begin
    if (!aresetn || !in_cpu || wd_restart
        || !watchdog_control_register_q.wd_enable) begin
      wd_cnt_q <= '0;
      pend_q <= 1'b0;
      pre_cnt_q <= '0;
    end else if (!pend_q) begin
      if (wd_int_set) begin
        wd_cnt_q <= '0;
        pend_q <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + rst_wdt_pkg::WD_CNT_W'(1);
      end
    end else begin
      pre_cnt_q <= pre_cnt_q + rst_wdt_pkg::PRE_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == rst_wdt_pkg::ST_BROWNOUT) begin
      watchdog_control_register_q <= rst_wdt_pkg::WDOG_CTRL_RST;
    end else begin
      watchdog_control_register_q.restart <= 1'b0;
      watchdog_control_register_q.rsvd <= 1'b0;
      if (state_q == rst_wdt_pkg::ST_SYSRST) begin
        watchdog_control_register_q.timeout_select <= 2'h0;
        watchdog_control_register_q.wd_enable <= 1'b0;
      end else if (wr_wdog) begin
        watchdog_control_register_q.timeout_select <= wr_data[5:4];
        watchdog_control_register_q.wd_enable <= wr_data[3];
      end
      if (wr_wdog) begin
        watchdog_control_register_q.por_flag <=
          watchdog_control_register_q.por_flag & wr_data[7];
        watchdog_control_register_q.watchdog_reset_flag <=
          watchdog_control_register_q.watchdog_reset_flag & wr_data[2];
        watchdog_control_register_q.wd_int_flag <=
          watchdog_control_register_q.wd_int_flag & wr_data[1];
      end
      if (wd_int_set) watchdog_control_register_q.wd_int_flag <= 1'b1;
      if (wd_trip)
        watchdog_control_register_q.watchdog_reset_flag <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == rst_wdt_pkg::ST_BROWNOUT) begin
      reset_control_register_q <= rst_wdt_pkg::RSTCN_RST;
    end else begin
      if (wr_rstcn) begin
        reset_control_register_q.host_flag <=
          reset_control_register_q.host_flag & wr_data[2];
        reset_control_register_q.pin_flag <=
          reset_control_register_q.pin_flag & wr_data[1];
        if (wr_data[0]) reset_control_register_q.programming_done_bit <= 1'b1;
      end
      if (state_q == rst_wdt_pkg::ST_SYSRST)
        reset_control_register_q.programming_done_bit <= 1'b0;
      if (in_cpu && !pin_s_q) reset_control_register_q.pin_flag <= 1'b1;
      if (host_hit) reset_control_register_q.host_flag <= 1'b1;
    end
  end

  // write channel, address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= rst_wdt_pkg::RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (aw_ok) waddr_q <= awaddr;
      if (w_ok) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      have_aw_q <= got_aw & ~do_write;
      have_w_q <= got_w & ~do_write;
      awready_q <= ~(got_aw & ~do_write) & ~do_write & ~(bvalid_q & ~bready);
      wready_q <= ~(got_w & ~do_write) & ~do_write & ~(bvalid_q & ~bready);
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_reg(wr_addr) ? rst_wdt_pkg::RESP_OKAY
                                   : rst_wdt_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= rst_wdt_pkg::RESP_OKAY;
    end else begin
      if (ar_ok) begin
        rvalid_q <= 1'b1;
        arready_q <= 1'b0;
        rresp_q <= is_reg(araddr) ? rst_wdt_pkg::RESP_OKAY
                                  : rst_wdt_pkg::RESP_SLVERR;
        if (araddr == rst_wdt_pkg::OFS_WDOG_CTRL)
          rdata_q <= {24'h000000, watchdog_control_register_q};
        else if (araddr == rst_wdt_pkg::OFS_RSTCN)
          rdata_q <= {24'h000000, reset_control_register_q};
        else
          rdata_q <= '0;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign core_clk_en = core_clk_en_q;
  assign por_reset = por_reset_q;
  assign sys_reset = sys_reset_q;
  assign fetch_start = fetch_start_q;
  assign boot_addr = boot_addr_q;
  assign wdt_irq = watchdog_control_register_q.wd_int_flag;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gate;
    state_q == rst_wdt_pkg::ST_BROWNOUT || state_q == rst_wdt_pkg::ST_SETTLE
      && settle_cnt_q != SW'(settle_cycles - 1) |=> !core_clk_en_q;
  endproperty
  a_gate: assert property (p_gate) else $error("core clock not gated");

  property p_bo;
    bo_s_q |=> state_q == rst_wdt_pkg::ST_BROWNOUT && sys_reset_q;
  endproperty
  a_bo: assert property (p_bo) else $error("brownout missed");

  property p_settle;
    state_q == rst_wdt_pkg::ST_SETTLE && bo_s_q
      |=> state_q == rst_wdt_pkg::ST_BROWNOUT;
  endproperty
  a_settle: assert property (p_settle) else $error("settle abort");

  property p_por;
    state_q == rst_wdt_pkg::ST_BROWNOUT
      |=> watchdog_control_register_q.por_flag && por_reset_q;
  endproperty
  a_por: assert property (p_por) else $error("startup flag");

  property p_wdrst;
    wd_trip |=> (state_q == rst_wdt_pkg::ST_SYSRST
      && watchdog_control_register_q.watchdog_reset_flag) [*4]
      ##1 (in_cpu || !pin_s_q || bo_s_q);
  endproperty
  a_wdrst: assert property (p_wdrst) else $error("wd reset width");

  property p_pre;
    wd_trip |-> $past(pend_q, 8);
  endproperty
  a_pre: assert property (p_pre) else $error("wd pre-reset");

  property p_boot;
    $fell(sys_reset_q) |-> fetch_start_q && boot_addr_q == 16'h8000;
  endproperty
  a_boot: assert property (p_boot) else $error("boot fetch");

  property p_pin;
    in_cpu && !pin_s_q && !bo_s_q
      |=> state_q == rst_wdt_pkg::ST_SYSRST && !por_reset_q;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset");

  property p_host;
    host_hit && !bo_s_q |=> sys_reset_q
      && reset_control_register_q.host_flag;
  endproperty
  a_host: assert property (p_host) else $error("host reset");

  c_boot: cover property ($fell(por_reset_q));
  c_wd: cover property (wd_trip);
  c_host: cover property (host_hit);
  c_pin: cover property (in_cpu && !pin_s_q);

endmodule // reset_and_watchdog_control

// File: reset_sources.sv
module reset_sources (
  input wire logic aclk,
  input wire logic bo_req,
  input wire logic pin_req,
  input wire logic host_go,
  input wire logic [7:0] host_byte,
  output logic brownout,
  output logic rst_pin_n,
  output logic host_cmd_valid,
  output logic [7:0] host_cmd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go_q;
  initial begin
    brownout = 1'b0;
    rst_pin_n = 1'b1;
    host_cmd_valid = 1'b0;
    host_cmd_data = 8'h00;
    go_q = 1'b0;
  end
  // supply monitor and pin are plain levels
  always @(posedge aclk) begin
    brownout <= bo_req;
    rst_pin_n <= !pin_req;
    go_q <= host_go;
  end
  // one byte per request; idle data toggles, so the last byte returns every other cycle
  always @(posedge aclk) begin
    host_cmd_valid <= host_go && !go_q;
    if (host_go && !go_q) begin
      host_cmd_data <= host_byte;
    end else begin
      host_cmd_data <= ~host_cmd_data;
    end
  end
endmodule // reset_sources

// File: tb_top.sv
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t: %s", $time, m); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, bo_req, pin_req, host_go;
  logic brownout, rst_pin_n, host_cmd_valid;
  logic [7:0] host_byte, host_cmd_data;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, rs_q, bs_q;
  logic core_clk_en, por_reset, sys_reset, fetch_start, wdt_irq;
  logic [15:0] boot_addr;
  int errors = 0;
  int cmp_count = 0;
  int n;
  int t;

  reset_and_watchdog_control #(.settle_cycles(20), .wd_base_log2(3)) dut (
    .aclk(aclk), .aresetn(aresetn), .brownout(brownout),
    .rst_pin_n(rst_pin_n), .host_cmd_valid(host_cmd_valid),
    .host_cmd_data(host_cmd_data), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .core_clk_en(core_clk_en), .por_reset(por_reset),
    .sys_reset(sys_reset), .fetch_start(fetch_start),
    .boot_addr(boot_addr), .wdt_irq(wdt_irq));

  reset_sources ext (.aclk(aclk), .bo_req(bo_req), .pin_req(pin_req),
    .host_go(host_go), .host_byte(host_byte), .brownout(brownout),
    .rst_pin_n(rst_pin_n), .host_cmd_valid(host_cmd_valid),
    .host_cmd_data(host_cmd_data));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bs_q = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd_q = rdata;
    rs_q = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return fetch_start;
      1: return wdt_irq;
      default: return sys_reset;
    endcase
  endfunction

  // counts edges until the chosen output is seen high
  task automatic wait_for(input int w, input int lim, output int c);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (sig(w) !== 1'b1 && c < lim);
    `CHK(sig(w), 1'b1, "awaited signal never came")
  endtask

  task automatic host_send(input logic [7:0] b);
    host_byte <= b;
    host_go <= 1'b1;
    @(posedge aclk);
    host_go <= 1'b0;
  endtask

  task automatic note(input string s);
    $display("test %s done, errors %0d", s, errors);
  endtask

  task automatic conclude;
    $display("compares %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    $display("mismatch at %0t: run hung", $time);
    conclude;
  end

  initial begin
    aresetn = 1'b0;
    {bo_req, pin_req, host_go, awvalid, wvalid, bready} = 6'h00;
    {arvalid, rready} = 2'h0;
    host_byte = 8'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(core_clk_en, 1'b0, "clock released early")
    `CHK(por_reset, 1'b1, "startup reset missing")
    wait_for(0, 100, n);
    `CHK(boot_addr, 16'h8000, "boot address")
    `CHK(core_clk_en, 1'b1, "clock not enabled")
    rd(12'h000);
    `CHK(rd_q[7:0], 8'h80, "startup flag")
    rd(12'h008);
    `CHK({rs_q, rd_q}, {2'h2, 32'h0}, "unmapped read")
    wr(12'h00C, 8'h00);
    `CHK(bs_q, 2'h2, "unmapped write")
    wr(12'h000, 8'h00);
    `CHK(bs_q, 2'h0, "write response")
    rd(12'h000);
    `CHK(rd_q[7:0], 8'h00, "flag not cleared")
    note("startup");
    for (int i = 0; i < 30; i++) wr(12'h000, 8'h19);
    `CHK(wdt_irq, 1'b0, "fired despite restart")
    wr(12'h000, 8'h00);
    note("restart");
    for (int s = 0; s < 4; s++) begin
      t = 1 << (3 + 3 * s);
      wr(12'h000, {2'b00, 2'(s), 4'h8});
      wait_for(1, t + 10, n);
      `CHK(n >= t - 4 && n <= t + 4, 1'b1, "timeout length")
      wait_for(2, 530, n);
      `CHK(n >= 510 && n <= 516, 1'b1, "irq to reset gap")
      n = 0;
      while (sys_reset === 1'b1 && n < 20) begin
        n++;
        @(posedge aclk);
      end
      `CHK(n, 4, "watchdog reset width")
      `CHK(fetch_start, 1'b1, "no restart pulse")
      rd(12'h000);
      `CHK(rd_q[5:2], 4'h1, "watchdog flag")
    end
    note("watchdog");
    host_send(8'hBA);
    repeat (8) @(posedge aclk);
    `CHK(sys_reset, 1'b0, "wrong command obeyed")
    host_send(8'hBB);
    wait_for(2, 8, n);
    `CHK(por_reset, 1'b0, "host reset too wide")
    wait_for(0, 20, n);
    rd(12'h004);
    `CHK(rd_q[2:0], 3'b100, "host flag")
    pin_req <= 1'b1;
    repeat (12) @(posedge aclk);
    `CHK(sys_reset, 1'b1, "pin reset missing")
    `CHK(por_reset, 1'b0, "pin reset too wide")
    pin_req <= 1'b0;
    wait_for(0, 30, n);
    rd(12'h004);
    `CHK(rd_q[2:0], 3'b110, "flags lost")
    wr(12'h004, 8'h01);
    wait_for(2, 8, n);
    `CHK(por_reset, 1'b0, "programming reset too wide")
    wait_for(0, 20, n);
    rd(12'h004);
    `CHK(rd_q[2:0], 3'b000, "done bit kept")
    note("sources");
    wr(12'h000, 8'h30);
    bo_req <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(por_reset, 1'b1, "brownout reset")
    `CHK(core_clk_en, 1'b0, "clock kept in brownout")
    bo_req <= 1'b0;
    repeat (10) @(posedge aclk);
    `CHK(core_clk_en, 1'b0, "settle cut short")
    bo_req <= 1'b1;
    repeat (4) @(posedge aclk);
    bo_req <= 1'b0;
    repeat (14) @(posedge aclk);
    `CHK(por_reset, 1'b1, "brownout in settle ignored")
    wait_for(0, 60, n);
    rd(12'h000);
    `CHK(rd_q[7:0], 8'h80, "brownout unlike startup")
    note("brownout");
    conclude;
  end
endmodule // tb_top
